// file: src/acd_pkg.sv
// How it works
// R1: converter over-range pulse sets sticky overflow status bit 3.
// R2: 24-bit mask bit enables interrupt of matching status bit.
// R3: unmasking an already pending bit raises the interrupt at once.
// R4: interrupt is a level, held while any enabled status bit pends.
// R5: four-bit gain field drives the amplifier's 16 linear gain steps.
// R6: boost bit adds 6 dB; power-down bit turns analog audio off.
// R7: source select: tuner, fm, mic/line, mixed source input.
// R8: sample edge bit picks rising (0) or falling (1) serial clock edge.
// R9: polarity bit names channel after word-select rise, or frame sync edge.
// R10: bit order bit picks msb first (0) or lsb first (1).
// R11: wait delay field serial clocks after word-select edge before sampling.
// R12: mode bit picks digital audio (0) or packet frame mode (1).
// R13: width bit gives 16-bit samples or rounded 8-bit samples.
// R14: second-stage bit adds a further decimation by two.
// R15: limit bit turns 0x8000 into 0x8001, or 0x80 into 0x81.
// R16: first-stage field sets decimation rate, software keeps 4 to 15.
// R17: io mode picks converter or digital input; flag picks fast modes.
// R18: capture bit admits data to fifo; fifo enable low flushes it.
// R19: burst starts once fifo holds 4, 8 or 16 dwords.
// R20: program enable rise loads counter from start address.
// R21: counter readback returns the prefetching program counter.
// R22: packet lengths hold lines per field and bytes per line.
package acd_pkg;
  localparam logic [11:0] OFS_STATUS = 12'h100;
  localparam logic [11:0] OFS_MASK = 12'h104;
  localparam logic [11:0] OFS_CTRL = 12'h10C;
  localparam logic [11:0] OFS_PKTLEN = 12'h110;
  localparam logic [11:0] OFS_START = 12'h114;
  localparam logic [11:0] OFS_PC = 12'h120;
  localparam logic [23:0] RST_MASK = 24'h000000;
  localparam logic [31:0] RST_CTRL = 32'h00000000;
  localparam logic [31:0] RST_START = 32'h00000000;
  localparam int STAT_CONVERTER_OVERFLOW_FLAG = 3;
  localparam int B_GAIN = 28;
  localparam int B_BOOST = 27;
  localparam int B_PWRDN = 26;
  localparam int B_SEL = 24;
  localparam int B_EDGE = 23;
  localparam int B_POL = 22;
  localparam int B_ORDER = 21;
  localparam int B_DELAY = 16;
  localparam int B_PKT = 15;
  localparam int B_WIDTH = 14;
  localparam int B_STAGE2 = 13;
  localparam int B_LIMIT = 12;
  localparam int B_RATE = 8;
  localparam int B_IOM = 6;
  localparam int B_FAST = 5;
  localparam int B_CAPT = 4;
  localparam int B_THR = 2;
  localparam int B_PROG = 1;
  localparam int B_FIFO = 0;
  localparam int B_LINES = 16;
  localparam logic [1:0] IOM_CONV = 2'h0;
  localparam logic [1:0] IOM_DIG = 2'h1;
  localparam logic [15:0] LIM16_IN = 16'h8000;
  localparam logic [15:0] LIM16_OUT = 16'h8001;
  localparam logic [7:0] LIM8_IN = 8'h80;
  localparam logic [7:0] LIM8_OUT = 8'h81;
  localparam logic [31:0] PC_STEP = 32'h00000004;
  typedef enum logic [1:0] {ACD_IDLE, ACD_DELAY, ACD_SHIFT} acd_ser_e;
endpackage

// file: src/acd_top.sv
`timescale 1ns/100ps
module acd_top
  import acd_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int AW = 5
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  input wire logic [23:0] event_set,
  input wire logic converter_over_range,
  input wire logic conv_valid,
  input wire logic [15:0] conv_sample,
  input wire logic serial_audio_clock,
  input wire logic word_select_clock,
  input wire logic serial_audio_data,
  output logic inta,
  output logic [3:0] audio_gain,
  output logic gain_boost_bit,
  output logic analog_power_down_bit,
  output logic [1:0] audio_source_sel,
  output logic [1:0] audio_io_mode,
  output logic parallel_highspeed_enable,
  output logic [7:0] lines_per_field,
  output logic [11:0] bytes_per_line,
  output logic burst_req,
  input wire logic dma_pop,
  output logic [31:0] dma_data,
  output logic [AW-1:0] fifo_level,
  output logic fetch_req,
  input wire logic fetch_ack,
  output logic [31:0] program_counter_value
);
  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [31:0] ctrl;
    logic [23:0] mask;
    logic [7:0] lines;
    logic [11:0] bytes;
    logic [31:0] start;
    logic [31:0] pc;
    logic prog_prev;
    logic [23:0] stat;
    logic [31:0] rdata;
    logic sck1;
    logic sck2;
    logic sck3;
    logic lr1;
    logic lr2;
    logic lr3;
    logic dat1;
    logic dat2;
    acd_ser_e ser;
    logic [4:0] dcnt;
    logic [4:0] bcnt;
    logic [15:0] shreg;
    logic right;
    logic [3:0] dec1;
    logic dec2;
    logic [31:0] pack;
    logic [1:0] lane;
    logic [DEPTH-1:0][31:0] mem;
    logic [AW-2:0] wptr;
    logic [AW-2:0] rptr;
    logic [AW-1:0] cnt;
  } acd_state_s;

  acd_state_s s_q;
  acd_state_s s_d;

  logic sck_edge;
  logic lr_rise;
  logic lr_fall;
  logic frame_edge;
  logic word_done;
  logic [15:0] word;
  logic in_valid;
  logic [15:0] in_sample;
  logic dec_out;
  logic [15:0] w16;
  logic [7:0] w8;
  logic push;
  logic pop;
  logic full;
  logic [AW-1:0] thr;
  logic [23:0] clr;

  ////////////////////////////////////////////////////////////////////////
  // pin edges
  always_comb
  begin
    sck_edge = s_q.ctrl[B_EDGE] ? (s_q.sck3 & ~s_q.sck2)
                                : (~s_q.sck3 & s_q.sck2); // R8
    lr_rise = ~s_q.lr3 & s_q.lr2;
    lr_fall = s_q.lr3 & ~s_q.lr2;
    if (s_q.ctrl[B_PKT]) // R12
    begin
      frame_edge = s_q.ctrl[B_POL] ? lr_fall : lr_rise; // R9
    end
    else
    begin
      frame_edge = lr_rise | lr_fall;
    end
  end

  // sample source and decimation
  always_comb
  begin
    word = s_q.ctrl[B_ORDER] ? {s_q.dat2, s_q.shreg[15:1]}
                             : {s_q.shreg[14:0], s_q.dat2}; // R10
    word_done = (s_q.ser == ACD_SHIFT) && sck_edge && (s_q.bcnt == 5'h0F);
    if (s_q.ctrl[B_IOM+:2] == IOM_CONV) // R17
    begin
      in_valid = conv_valid;
      in_sample = conv_sample;
    end
    else if (s_q.ctrl[B_IOM+:2] == IOM_DIG)
    begin
      in_valid = word_done;
      in_sample = word;
    end
    else
    begin
      in_valid = 1'b0;
      in_sample = 16'h0000;
    end
    dec_out = in_valid && ((s_q.dec1 + 4'h1) >= s_q.ctrl[B_RATE+:4]) // R16
              && (~s_q.ctrl[B_STAGE2] || s_q.dec2); // R14
    w16 = in_sample;
    if (s_q.ctrl[B_LIMIT] && w16 == LIM16_IN)
    begin
      w16 = LIM16_OUT; // R15
    end
    if (in_sample[15:8] == 8'h7F && in_sample[7])
    begin
      w8 = 8'h7F;
    end
    else
    begin
      w8 = in_sample[15:8] + {7'h00, in_sample[7]}; // R13
    end
    if (s_q.ctrl[B_LIMIT] && w8 == LIM8_IN)
    begin
      w8 = LIM8_OUT; // R15
    end
  end

  // fifo flags
  always_comb
  begin
    full = (s_q.cnt == AW'(DEPTH));
    case (s_q.ctrl[B_THR+:2]) // R19
      2'h0: thr = AW'(4);
      2'h1: thr = AW'(8);
      default: thr = AW'(16);
    endcase
    pop = dma_pop && (s_q.cnt != '0);
    push = 1'b0;
    if (dec_out && s_q.ctrl[B_CAPT] && s_q.ctrl[B_FIFO]) // R18
    begin
      push = s_q.ctrl[B_WIDTH] ? (s_q.lane == 2'h3) : s_q.lane[0];
      push = push && !full;
    end
    clr = (reg_wr && reg_addr == OFS_STATUS) ? reg_wdata[23:0] : 24'h000000;
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    s_d = s_q;
    // synchronisers
    s_d.sck1 = serial_audio_clock;
    s_d.sck2 = s_q.sck1;
    s_d.sck3 = s_q.sck2;
    s_d.lr1 = word_select_clock;
    s_d.lr2 = s_q.lr1;
    s_d.lr3 = s_q.lr2;
    s_d.dat1 = serial_audio_data;
    s_d.dat2 = s_q.dat1;

    // register writes
    if (reg_wr)
    begin
      unique case (reg_addr)
        OFS_MASK: s_d.mask = reg_wdata[23:0]; // R2
        OFS_CTRL: s_d.ctrl = reg_wdata;
        OFS_PKTLEN:
        begin
          s_d.lines = reg_wdata[B_LINES+:8]; // R22
          s_d.bytes = reg_wdata[11:0]; // R22
        end
        OFS_START: s_d.start = reg_wdata; // R20
        default: ;
      endcase
    end

    // status: set beats clear
    s_d.stat = (s_q.stat & ~clr) | event_set;
    if (converter_over_range)
    begin
      s_d.stat[STAT_CONVERTER_OVERFLOW_FLAG] = 1'b1; // R1
    end

    // register reads
    if (reg_rd)
    begin
      unique case (reg_addr)
        OFS_STATUS: s_d.rdata = {8'h00, s_q.stat};
        OFS_MASK: s_d.rdata = {8'h00, s_q.mask};
        OFS_CTRL: s_d.rdata = s_q.ctrl;
        OFS_PKTLEN: s_d.rdata = {8'h00, s_q.lines, 4'h0, s_q.bytes};
        OFS_START: s_d.rdata = s_q.start;
        OFS_PC: s_d.rdata = s_q.pc; // R21
        default: s_d.rdata = 32'h00000000;
      endcase
    end

    // program counter
    s_d.prog_prev = s_q.ctrl[B_PROG];
    if (s_q.ctrl[B_PROG] && !s_q.prog_prev)
    begin
      s_d.pc = s_q.start; // R20
    end
    else if (s_q.ctrl[B_PROG] && fetch_ack)
    begin
      s_d.pc = s_q.pc + PC_STEP; // R21
    end

    // serial word capture
    unique case (s_q.ser)
      ACD_IDLE:
      begin
        if (frame_edge)
        begin
          s_d.right = s_q.ctrl[B_PKT] ? 1'b0 : (lr_rise ^ ~s_q.ctrl[B_POL]); // R9
          s_d.dcnt = s_q.ctrl[B_DELAY+:5];
          s_d.bcnt = 5'h00;
          s_d.ser = (s_q.ctrl[B_DELAY+:5] == 5'h00) ? ACD_SHIFT : ACD_DELAY;
        end
      end
      ACD_DELAY:
      begin
        if (sck_edge)
        begin
          s_d.dcnt = s_q.dcnt - 5'h01; // R11
          if (s_q.dcnt == 5'h01)
          begin
            s_d.ser = ACD_SHIFT;
          end
        end
      end
      ACD_SHIFT:
      begin
        if (sck_edge)
        begin
          s_d.shreg = word;
          s_d.bcnt = s_q.bcnt + 5'h01;
          if (s_q.bcnt == 5'h0F)
          begin
            s_d.ser = ACD_IDLE;
          end
        end
      end
    endcase
    if (s_q.ctrl[B_IOM+:2] != IOM_DIG)
    begin
      s_d.ser = ACD_IDLE;
    end

    // decimation counters
    if (in_valid)
    begin
      if ((s_q.dec1 + 4'h1) >= s_q.ctrl[B_RATE+:4]) // R16
      begin
        s_d.dec1 = 4'h0;
        s_d.dec2 = s_q.ctrl[B_STAGE2] ? ~s_q.dec2 : 1'b0; // R14
      end
      else
      begin
        s_d.dec1 = s_q.dec1 + 4'h1;
      end
    end

    // packing and fifo
    if (dec_out && s_q.ctrl[B_CAPT] && s_q.ctrl[B_FIFO]) // R18
    begin
      if (s_q.ctrl[B_WIDTH]) // R13
      begin
        s_d.pack[s_q.lane*8+:8] = w8;
        s_d.lane = s_q.lane + 2'h1;
      end
      else
      begin
        s_d.pack[s_q.lane[0]*16+:16] = w16;
        s_d.lane = {1'b0, ~s_q.lane[0]};
      end
    end
    if (push)
    begin
      s_d.mem[s_q.wptr] = s_d.pack;
      s_d.wptr = s_q.wptr + 1'b1;
    end
    if (pop)
    begin
      s_d.rptr = s_q.rptr + 1'b1;
    end
    s_d.cnt = s_q.cnt + AW'(push) - AW'(pop);
    if (!s_q.ctrl[B_FIFO]) // R18
    begin
      s_d.wptr = '0;
      s_d.rptr = '0;
      s_d.cnt = '0;
      s_d.lane = 2'h0;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_q <= '0;
      s_q.ctrl <= RST_CTRL;
      s_q.mask <= RST_MASK;
      s_q.start <= RST_START;
      s_q.ser <= ACD_IDLE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign reg_rdata = s_q.rdata;
  assign inta = |(s_q.stat & s_q.mask); // R3 R4
  assign audio_gain = s_q.ctrl[B_GAIN+:4]; // R5
  assign gain_boost_bit = s_q.ctrl[B_BOOST]; // R6
  assign analog_power_down_bit = s_q.ctrl[B_PWRDN]; // R6
  assign audio_source_sel = s_q.ctrl[B_SEL+:2]; // R7
  assign audio_io_mode = s_q.ctrl[B_IOM+:2]; // R17
  assign parallel_highspeed_enable = s_q.ctrl[B_FAST]; // R17
  assign lines_per_field = s_q.lines;
  assign bytes_per_line = s_q.bytes;
  assign burst_req = s_q.ctrl[B_FIFO] && (s_q.cnt >= thr); // R19
  assign dma_data = s_q.mem[s_q.rptr];
  assign fifo_level = s_q.cnt;
  assign fetch_req = s_q.ctrl[B_PROG] && s_q.prog_prev;
  assign program_counter_value = s_q.pc;
endmodule

// file: tb/acd_top_sva.sv
`timescale 1ns/100ps
module acd_chk
  import acd_pkg::*;
#(
  parameter int AW = 5
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [31:0] reg_wdata,
  input wire logic [23:0] event_set,
  input wire logic converter_over_range,
  input wire logic inta,
  input wire logic [3:0] audio_gain,
  input wire logic gain_boost_bit,
  input wire logic [1:0] audio_source_sel,
  input wire logic [1:0] audio_io_mode,
  input wire logic [7:0] lines_per_field,
  input wire logic [11:0] bytes_per_line,
  input wire logic burst_req,
  input wire logic [AW-1:0] fifo_level,
  input wire logic fetch_req,
  input wire logic fetch_ack,
  input wire logic [31:0] program_counter_value
);
  wire wc = reg_wr && reg_addr == OFS_CTRL;
  logic [31:0] start_q;
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      start_q <= '0;
    else if (reg_wr && reg_addr == OFS_START)
      start_q <= reg_wdata;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  //////////////////////////////////////////////////////////////////////////////
  a_ctrl_gain: assert property (
    wc |=> audio_gain == $past(reg_wdata[31:28]) && gain_boost_bit == $past(reg_wdata[27]))
    else $error("gain fields wrong");
  a_ctrl_sel: assert property (
    wc |=> audio_source_sel == $past(reg_wdata[25:24]) && audio_io_mode == $past(reg_wdata[7:6]))
    else $error("select fields wrong");
  a_pkt_len: assert property (
    reg_wr && reg_addr == OFS_PKTLEN |=> lines_per_field == $past(reg_wdata[23:16])
    && bytes_per_line == $past(reg_wdata[11:0])) else $error("packet lengths wrong");
  a_inta_off: assert property (
    reg_wr && reg_addr == OFS_MASK && reg_wdata[23:0] == 24'h000000 |=> !inta)
    else $error("inta with empty mask");
  a_inta_rise: assert property (
    $rose(inta) |-> $past(converter_over_range || (|event_set) || reg_wr))
    else $error("inta rose without cause");
  a_inta_fall: assert property (
    $fell(inta) |-> $past(reg_wr)) else $error("inta fell without write");
  a_pc_load: assert property (
    wc && reg_wdata[1] && !fetch_req |-> ##2 fetch_req && program_counter_value == start_q)
    else $error("counter not loaded");
  a_pc_step: assert property (
    fetch_req && fetch_ack |=> program_counter_value == $past(program_counter_value) + PC_STEP)
    else $error("counter step wrong");
  a_burst_min: assert property (
    burst_req |-> fifo_level >= 4) else $error("burst below threshold");
endmodule
bind acd_top acd_chk #(.AW(AW)) u_chk (
  .clk(clk),
  .rst_b(rst_b),
  .reg_addr(reg_addr),
  .reg_wr(reg_wr),
  .reg_wdata(reg_wdata),
  .event_set(event_set),
  .converter_over_range(converter_over_range),
  .inta(inta),
  .audio_gain(audio_gain),
  .gain_boost_bit(gain_boost_bit),
  .audio_source_sel(audio_source_sel),
  .audio_io_mode(audio_io_mode),
  .lines_per_field(lines_per_field),
  .bytes_per_line(bytes_per_line),
  .burst_req(burst_req),
  .fifo_level(fifo_level),
  .fetch_req(fetch_req),
  .fetch_ack(fetch_ack),
  .program_counter_value(program_counter_value)
);

// file: tb/acd_ser_src.sv
`timescale 1ns/100ps
module acd_ser_src
(
  output logic sclk,
  output logic ws,
  output logic sd
);
  initial
  begin
    sclk = 1'b0;
    ws = 1'b0;
    sd = 1'b0;
  end
  // frame edge, delay clocks, then 16 bits; clock still between frames
  // data moves mid-low, so both sample edges see it settled
  task automatic send(input logic [15:0] w, input int dly, input logic lsb);
    ws = ~ws;
    #0.3;
    for (int i = 0; i < dly + 16; i++)
    begin
      #16 sd = (i < dly) ? ~sd : w[lsb ? i - dly : 15 + dly - i];
      #16 sclk = 1'b1;
      #32 sclk = 1'b0;
    end
    #16 sd = ~sd;
  endtask
endmodule

// file: tb/test_acd_top.sv
`timescale 1ns/100ps
module test_acd_top;
  import acd_pkg::*;
  logic clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, rd_q = 0, inta, burst_req, fetch_req;
  logic converter_over_range = 0, conv_valid = 0, dma_pop = 0, fetch_ack = 0;
  logic gain_boost_bit, analog_power_down_bit, parallel_highspeed_enable;
  logic serial_audio_clock, word_select_clock, serial_audio_data;
  logic [1:0] audio_source_sel, audio_io_mode;
  logic [3:0] audio_gain;
  logic [4:0] fifo_level;
  logic [7:0] lines_per_field;
  logic [11:0] reg_addr = 0, bytes_per_line;
  logic [15:0] conv_sample = 0;
  logic [23:0] event_set = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, dma_data, program_counter_value, rs = 32'h8435E509;
  logic [31:0] eq[$];
  int mismatches = 0, samples_checked = 0, cyc = 0;
  acd_top uut (.*);
  acd_ser_src src (.sclk(serial_audio_clock), .ws(word_select_clock), .sd(serial_audio_data));
  always #2.5 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    tick();
    reg_wr = 0;
    tick();
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    reg_addr = a;
    reg_rd = 1;
    eq.push_back(e);
    tick();
    reg_rd = 0;
    tick();
  endtask
  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // result watcher: read data and popped dwords against oldest note
  always @(negedge clk)
  begin
    cyc++;
    if (rd_q || dma_pop)
      chk(rd_q ? reg_rdata : dma_data, eq.pop_front());
    rd_q <= reg_rd;
    if (cyc == 30000)
    begin
      mismatches++;
      summarize();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [31:0] d, s;
    logic [15:0] v;
    tick(4);
    rst_b = 1;
    tick();
    rd(OFS_MASK, 0);
    rd(OFS_START, 0);
    rd(12'h1FC, 0);
    for (int i = 0; i < 4; i++)
    begin
      d = rnd() & 32'hFCFFFF3C | (i << 24) | (i << 6);
      wr(OFS_CTRL, d);
      chk({audio_gain, gain_boost_bit, analog_power_down_bit, audio_source_sel}, d[31:24]);
      chk({audio_io_mode, parallel_highspeed_enable}, d[7:5]);
      rd(OFS_CTRL, d);
    end
    d = rnd();
    wr(OFS_PKTLEN, d);
    chk({lines_per_field, bytes_per_line}, {d[23:16], d[11:0]});
    rd(OFS_PKTLEN, d & 32'h00FF0FFF);
    $display("register test done");
    wr(OFS_CTRL, 0);
    wr(OFS_MASK, 0);
    converter_over_range = 1;
    event_set = 24'h000020;
    tick();
    converter_over_range = 0;
    event_set = 0;
    tick();
    chk(inta, 0);
    rd(OFS_STATUS, 32'h00000028);
    wr(OFS_MASK, 32'h00000008);
    chk(inta, 1);
    wr(OFS_STATUS, 32'h00000008);
    chk(inta, 0);
    wr(OFS_MASK, 32'h00000020);
    chk(inta, 1);
    wr(OFS_MASK, 0);
    chk(inta, 0);
    $display("interrupt test done");
    s = rnd() & 32'hFFFFFFFC;
    wr(OFS_START, s);
    wr(OFS_CTRL, 32'h00000002);
    chk(fetch_req, 1);
    chk(program_counter_value, s);
    fetch_ack = 1;
    tick(3);
    fetch_ack = 0;
    wr(OFS_PC, 0);
    rd(OFS_PC, s + 12);
    wr(OFS_CTRL, 0);
    $display("counter test done");
    for (int m = 0; m < 2; m++)
    begin
      wr(OFS_CTRL, 32'h00001411 | (m << 13) | (m << 14));
      for (int w = 0; w < 4; w++)
      begin
        for (int k = 0; k < 2 + 2 * m; k++)
        begin
          s = rnd();
          v = (w + k == 0) ? 16'h8000 : (m ? {1'b0, s[14:8], 8'h00} : s[15:0]);
          if (m)
            d[k*8 +: 8] = (v[15:8] == 8'h80) ? 8'h81 : v[15:8];
          else
            d[k*16 +: 16] = (v == 16'h8000) ? 16'h8001 : v;
          conv_sample = v;
          conv_valid = 1;
          tick(4 + 4 * m);
        end
        eq.push_back(d);
      end
      conv_valid = 0;
      tick(2);
      chk(fifo_level, 4);
      chk(burst_req, 1);
      wr(OFS_CTRL, 32'h00001411 | (m << 13) | (m << 14) | (4 << m));
      chk(burst_req, 0);
      dma_pop = 1;
      tick(4 - 2 * m);
      dma_pop = 0;
      eq.delete();
      wr(OFS_CTRL, 0);
      chk(fifo_level, 0);
    end
    $display("fifo test done");
    for (int o = 0; o < 4; o++)
    begin
      wr(OFS_CTRL, 32'h00020451 | ((o % 2) << 21) | ((o / 2) << 23) | ((o / 3) << 15));
      s = rnd();
      repeat (8 << (o / 3)) src.send(s[15:0], 2, o[0]);
      tick(4);
      chk(fifo_level, 1);
      eq.push_back({s[15:0], s[15:0]});
      dma_pop = 1;
      tick();
      dma_pop = 0;
      wr(OFS_CTRL, 0);
    end
    $display("serial test done");
    summarize();
  end
endmodule
